// ---- dv/fpx_mem_model.sv ----
`timescale 1ns/1ps
module fpx_mem_model (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 slow,
	input  wire logic                 memValid,
	output logic                      memReady,
	input  wire fpx_pkg::fpx_mem_type memReq,
	output logic                      memRspValid,
	output logic [31:0]               memRdata
);
	import fpx_pkg::*;
	logic [31:0] mem [logic [31:0]];
	logic        rspHold;
	logic [31:0] dataHold;
	// Answers come two cycles after the request, so a barrier can find one in flight.
	// Read data flips every cycle outside an answer so stale values never pass.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			memReady <= 1'b1;
			memRspValid <= 1'b0;
			memRdata <= 32'h0;
			rspHold <= 1'b0;
			dataHold <= 32'h0;
		end else begin
			memReady <= !slow || !memReady;
			rspHold <= memValid && memReady;
			memRspValid <= rspHold;
			memRdata <= dataHold;
			dataHold <= ~dataHold;
			if (memValid && memReady) begin
				if (memReq.write)
					mem[memReq.addr] = memReq.wdata;
				else if (mem.exists(memReq.addr))
					dataHold <= mem[memReq.addr];
			end
		end
	end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
	import fpx_pkg::*;
	logic          core_clk;
	logic          rst;
	logic          instrValid;
	logic          instrReady;
	fpx_instr_type instr;
	logic          memValid;
	logic          memReady;
	fpx_mem_type   memReq;
	logic          memRspValid;
	logic [31:0]   memRdata;
	fpx_wb_type    coreWb;
	logic          fpWrEn;
	logic [4:0]    fpWrIdx;
	logic [31:0]   fpWrData;
	logic [4:0]    fpRdIdx;
	logic [31:0]   fpRdData;
	logic          flagsLoad;
	logic [3:0]    flagsIn;
	logic [3:0]    flags;
	logic          intPriorityMask;
	logic          faultMaskA;
	logic          debugHalted;
	logic          debugResume;
	logic          undefinedInstr;
	logic          memSlow;
	logic [3:0]    wbIdx;
	logic [31:0]   wbVal;
	int            undefCnt;
	int            failures;
	int            cmpCount;

	fpx_exec fpx_exec_inst (
		.core_clk(core_clk), .rst(rst), .instrValid(instrValid),
		.instrReady(instrReady), .instr(instr), .memValid(memValid),
		.memReady(memReady), .memReq(memReq), .memRspValid(memRspValid),
		.memRdata(memRdata), .coreWb(coreWb), .fpWrEn(fpWrEn),
		.fpWrIdx(fpWrIdx), .fpWrData(fpWrData), .fpRdIdx(fpRdIdx),
		.fpRdData(fpRdData), .flagsLoad(flagsLoad), .flagsIn(flagsIn),
		.flags(flags), .intPriorityMask(intPriorityMask),
		.faultMaskA(faultMaskA), .debugHalted(debugHalted),
		.debugResume(debugResume), .undefinedInstr(undefinedInstr)
	);
	fpx_mem_model mem_inst (
		.core_clk(core_clk), .rst(rst), .slow(memSlow), .memValid(memValid),
		.memReady(memReady), .memReq(memReq), .memRspValid(memRspValid),
		.memRdata(memRdata)
	);

	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (coreWb.valid === 1'b1) begin
			wbIdx <= coreWb.idx;
			wbVal <= coreWb.value;
		end
		if (undefinedInstr === 1'b1)
			undefCnt <= undefCnt + 1;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic fpx_instr_type mk(input fpx_op_type op);
		fpx_instr_type i;
		i = '0;
		i.op = op;
		i.condPass = 1'b1;
		i.privileged = 1'b1;
		return i;
	endfunction

	// Holds the request from a falling edge through the rising edge that takes it.
	task automatic issue(input fpx_instr_type i, input bit waitDone);
		int n;
		n = 0;
		while (instrReady !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (instrReady !== 1'b1) chk(32'(instrReady), 32'h1);
		instrValid = 1'b1;
		instr = i;
		@(negedge core_clk);
		instrValid = 1'b0;
		n = 0;
		while (waitDone && instrReady !== 1'b1 && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		if (waitDone && instrReady !== 1'b1) chk(32'(instrReady), 32'h1);
		repeat (2) @(negedge core_clk);
	endtask

	task automatic bad(input fpx_instr_type i);
		int u;
		u = undefCnt;
		issue(i, 1'b1);
		chk(32'(undefCnt - u), 32'h1);
	endtask

	task automatic wr(input logic [4:0] idx, input logic [31:0] d);
		fpWrEn = 1'b1;
		fpWrIdx = idx;
		fpWrData = d;
		@(negedge core_clk);
		fpWrEn = 1'b0;
	endtask

	task automatic rd(input logic [4:0] idx, input logic [31:0] e);
		fpRdIdx = idx;
		#1;
		chk(fpRdData, e);
		@(negedge core_clk);
	endtask

	task automatic t_push_pop();
		fpx_instr_type i;
		wr(5'h4, 32'h1111_AAAA);
		wr(5'h5, 32'h2222_BBBB);
		memSlow = 1'b1;
		i = mk(OP_PUSH);
		i.first = 5'h4;
		i.count = 6'h2;
		i.baseVal = 32'h100;
		i.sizeGiven = 1'b1;
		i.sizeBits = SIZE_SINGLE;
		issue(i, 1'b1);
		chk(mem_inst.mem[32'hF8], 32'h1111_AAAA);
		chk(mem_inst.mem[32'hFC], 32'h2222_BBBB);
		chk(32'(wbIdx), 32'hD);
		chk(wbVal, 32'hF8);
		i = mk(OP_POP);
		i.dbl = 1'b1;
		i.first = 5'h3;
		i.count = 6'h1;
		i.baseVal = 32'hF8;
		issue(i, 1'b1);
		rd(5'h6, 32'h1111_AAAA);
		rd(5'h7, 32'h2222_BBBB);
		chk(wbVal, 32'h100);
		memSlow = 1'b0;
		i.count = 6'h0;
		bad(i);
		i.dbl = 1'b0;
		i.count = 6'h11;
		bad(i);
		i = mk(OP_PUSH);
		bad(i);
	endtask

	task automatic t_stm();
		fpx_instr_type i;
		wr(5'h0, 32'hA0A0_0000);
		wr(5'h1, 32'hA1A1_0001);
		i = mk(OP_STM);
		i.count = 6'h2;
		i.baseIdx = 4'h3;
		i.baseVal = 32'h200;
		issue(i, 1'b1);
		chk(mem_inst.mem[32'h200], 32'hA0A0_0000);
		chk(mem_inst.mem[32'h204], 32'hA1A1_0001);
		i.decBefore = 1'b1;
		i.writeback = 1'b1;
		i.baseVal = 32'h300;
		wbVal = 32'h0;
		issue(i, 1'b1);
		chk(mem_inst.mem[32'h2F8], 32'hA0A0_0000);
		chk(mem_inst.mem[32'h2FC], 32'hA1A1_0001);
		chk(32'(wbIdx), 32'h3);
		chk(wbVal, 32'h2F8);
		i.writeback = 1'b0;
		bad(i);
		i.writeback = 1'b1;
		i.count = 6'h0;
		bad(i);
		i.count = 6'h1;
		i.sizeGiven = 1'b1;
		i.sizeBits = SIZE_DOUBLE;
		bad(i);
	endtask

	task automatic t_str();
		fpx_instr_type i;
		wr(5'h9, 32'h5A5A_0001);
		i = mk(OP_STR);
		i.first = 5'h9;
		i.baseVal = 32'h400;
		i.immAdd = 1'b1;
		i.imm = 10'h3FC;
		issue(i, 1'b1);
		chk(mem_inst.mem[32'h7FC], 32'h5A5A_0001);
		i.immAdd = 1'b0;
		i.imm = 10'h8;
		issue(i, 1'b1);
		chk(mem_inst.mem[32'h3F8], 32'h5A5A_0001);
		i.imm = 10'h2;
		bad(i);
		i.dbl = 1'b1;
		i.first = 5'h2;
		i.imm = 10'h0;
		i.baseVal = 32'h500;
		issue(i, 1'b1);
		chk(mem_inst.mem[32'h500], 32'h1111_AAAA);
		chk(mem_inst.mem[32'h504], 32'h2222_BBBB);
	endtask

	task automatic t_arith();
		fpx_instr_type i;
		wr(5'hA, 32'h4080_0000);
		wr(5'hB, 32'h4040_0000);
		wr(5'hC, 32'h3F80_0000);
		i = mk(OP_STR);
		i.first = 5'hA;
		i.baseVal = 32'h600;
		// The barrier follows the store at once, while the store's answer is in flight.
		instrValid = 1'b1;
		instr = i;
		@(negedge core_clk);
		instr = mk(OP_DMB);
		repeat (2) @(negedge core_clk);
		instrValid = 1'b0;
		chk(32'(fpx_exec_inst.st.fence), 32'h1);
		chk(32'(instrReady), 32'h1);
		chk(mem_inst.mem[32'h600], 32'h4080_0000);
		i = mk(OP_SQRT);
		i.srcN = 5'hA;
		i.srcM = 5'hA;
		i.dst = 5'hD;
		issue(i, 1'b1);
		rd(5'hD, 32'h4000_0000);
		i = mk(OP_SUB);
		i.srcN = 5'hB;
		i.srcM = 5'hC;
		i.dst = 5'hE;
		issue(i, 1'b1);
		rd(5'hE, 32'h4000_0000);
	endtask

	task automatic t_breakpoint_instr();
		fpx_instr_type i;
		for (int k = 0; k < 2; k++) begin
			i = mk(OP_BREAKPOINT_INSTR);
			i.condPass = 1'b0;
			i.bkptImm = k ? 8'hAB : 8'h00;
			issue(i, 1'b0);
			chk(32'(debugHalted), 32'h1);
			chk(32'(instrReady), 32'h0);
			debugResume = 1'b1;
			@(negedge core_clk);
			debugResume = 1'b0;
			@(negedge core_clk);
			chk(32'(debugHalted), 32'h0);
		end
	endtask

	task automatic t_cps();
		fpx_instr_type i;
		logic [5:0]    tbl [5];
		tbl = '{6'h3A, 6'h37, 6'h0F, 6'h26, 6'h28};
		for (int k = 0; k < 5; k++) begin
			i = mk(OP_CPS);
			i.privileged = tbl[k][5];
			i.setMask = tbl[k][4];
			i.maskI = tbl[k][3];
			i.maskF = tbl[k][2];
			issue(i, 1'b1);
			chk(32'({intPriorityMask, faultMaskA}), 32'(tbl[k][1:0]));
		end
	endtask

	initial begin
		#160000;
		failures++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		instrValid = 1'b0;
		instr = '0;
		fpWrEn = 1'b0;
		fpWrIdx = 5'h0;
		fpWrData = 32'h0;
		fpRdIdx = 5'h0;
		flagsLoad = 1'b0;
		flagsIn = 4'h0;
		debugResume = 1'b0;
		memSlow = 1'b0;
		wbIdx = 4'h0;
		wbVal = 32'h0;
		undefCnt = 0;
		failures = 0;
		cmpCount = 0;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		flagsLoad = 1'b1;
		flagsIn = 4'hA;
		@(negedge core_clk);
		flagsLoad = 1'b0;
		t_push_pop();
		t_stm();
		t_str();
		t_arith();
		t_breakpoint_instr();
		t_cps();
		chk(32'(flags), 32'hA);
		report_and_stop();
	end
endmodule

// ---- hw/fpx_arith.sv ----
`timescale 1ns/1ps
module fpx_arith (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic        sqrtOp,
	input  wire logic [31:0] opA,
	input  wire logic [31:0] opB,
	output wire logic        done,
	output wire logic [31:0] result
);
	import fpx_pkg::*;

	typedef enum logic [1:0] {AR_IDLE, AR_NORM, AR_ROOT} fpx_ar_phase_type;
	typedef struct packed {
		fpx_ar_phase_type   phase;
		logic               sign;
		logic signed [9:0]  exp;
		logic [25:0]        mant;
		logic [47:0]        rad;
		logic [23:0]        root;
		logic [25:0]        rem;
		logic [4:0]         cnt;
		logic [31:0]        res;
		logic               done;
	} fpx_ar_state_type;

	fpx_ar_state_type st;
	fpx_ar_state_type next_st;
	localparam logic signed [9:0] BIAS_S = signed'({2'b00, EXP_BIAS});

	// Truncating arithmetic; subnormal inputs are taken as zero.
	always_comb begin
		logic [31:0] x;
		logic [31:0] y;
		logic [25:0] my;
		logic signed [9:0] e;
		logic [25:0] rem2;
		logic [25:0] trial;
		x = opA;
		y = {~opB[31], opB[30:0]};
		my = '0;
		e = '0;
		rem2 = {st.rem[23:0], st.rad[47:46]};
		trial = {st.root, 2'b01};
		next_st = st;
		next_st.done = 1'b0;
		unique case (st.phase)
			AR_IDLE: if (go && sqrtOp) begin
				e = signed'({2'b00, opA[30:23]}) - BIAS_S;
				next_st.done = 1'b1;
				if (opA[30:23] == '0) next_st.res = {opA[31], 31'h0};
				else if (opA[31]) next_st.res = QUIET_NAN;
				else if (opA[30:23] == EXP_MAX) next_st.res = opA;
				else begin
					next_st.done = 1'b0;
					next_st.rad = e[0] ? {1'b1, opA[22:0], 24'h0} : {1'b0, 1'b1, opA[22:0], 23'h0};
					next_st.exp = (e >>> 1) + BIAS_S;
					next_st.root = '0;
					next_st.rem = '0;
					next_st.cnt = SQRT_STEPS;
					next_st.phase = AR_ROOT;
				end
			end else if (go) begin
				if (opA[30:0] < y[30:0]) begin
					x = y;
					y = opA;
				end
				my = (y[30:23] == '0) ? '0 : ({2'b01, y[22:0], 1'b0} >> (x[30:23] - y[30:23]));
				next_st.sign = x[31];
				next_st.exp = signed'({2'b00, x[30:23]});
				next_st.mant = (x[31] == y[31]) ? ({2'b01, x[22:0], 1'b0} + my)
					: ({2'b01, x[22:0], 1'b0} - my);
				if (x[30:23] == '0) begin
					next_st.res = '0;
					next_st.done = 1'b1;
				end else next_st.phase = AR_NORM;
			end
			AR_NORM: begin
				if (st.mant == '0 || st.exp <= 0) begin
					next_st.res = (st.mant == '0) ? '0 : {st.sign, 31'h0};
					next_st.done = 1'b1;
					next_st.phase = AR_IDLE;
				end else if (st.mant[25]) begin
					next_st.mant = st.mant >> 1;
					next_st.exp = st.exp + 10'sd1;
				end else if (!st.mant[24]) begin
					next_st.mant = st.mant << 1;
					next_st.exp = st.exp - 10'sd1;
				end else begin
					next_st.res = (st.exp >= signed'({2'b00, EXP_MAX})) ? {st.sign, EXP_MAX, 23'h0}
						: {st.sign, st.exp[7:0], st.mant[23:1]};
					next_st.done = 1'b1;
					next_st.phase = AR_IDLE;
				end
			end
			AR_ROOT: begin
				next_st.rad = st.rad << 2;
				next_st.rem = (rem2 >= trial) ? rem2 - trial : rem2;
				next_st.root = {st.root[22:0], rem2 >= trial};
				next_st.cnt = st.cnt - 5'h1;
				if (st.cnt == 5'h1) begin
					next_st.res = {1'b0, st.exp[7:0], st.root[21:0], rem2 >= trial};
					next_st.done = 1'b1;
					next_st.phase = AR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) st <= '0;
		else st <= next_st;
	end

	assign done = st.done;
	assign result = st.res;
endmodule

// ---- hw/fpx_exec.sv ----
`timescale 1ns/1ps
module fpx_exec (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  instrValid,
	output wire logic                  instrReady,
	input  wire fpx_pkg::fpx_instr_type instr,
	output wire logic                  memValid,
	input  wire logic                  memReady,
	output wire fpx_pkg::fpx_mem_type  memReq,
	input  wire logic                  memRspValid,
	input  wire logic [31:0]           memRdata,
	output wire fpx_pkg::fpx_wb_type   coreWb,
	input  wire logic                  fpWrEn,
	input  wire logic [4:0]            fpWrIdx,
	input  wire logic [31:0]           fpWrData,
	input  wire logic [4:0]            fpRdIdx,
	output wire logic [31:0]           fpRdData,
	input  wire logic                  flagsLoad,
	input  wire logic [3:0]            flagsIn,
	output wire logic [3:0]            flags,
	output wire logic                  intPriorityMask,
	output wire logic                  faultMaskA,
	output wire logic                  debugHalted,
	input  wire logic                  debugResume,
	output wire logic                  undefinedInstr
);
	import fpx_pkg::*;

	typedef enum logic [1:0] {PH_IDLE, PH_XFER, PH_DRAIN, PH_ARITH} fpx_phase_type;

	typedef struct packed {
		fpx_phase_type     phase;
		logic [31:0][31:0] fregs;
		logic [31:0]       addr;
		logic [5:0]        wordIdx;
		logic [5:0]        wordsLeft;
		logic [5:0]        rspIdx;
		logic [5:0]        rspLeft;
		logic              isLoad;
		logic              started;
		logic [6:0]        outstanding;
		logic              fence;
		fpx_wb_type        wbPend;
		fpx_wb_type        wb;
		logic [4:0]        dst;
		logic              arithGo;
		logic              arithSqrt;
		logic [31:0]       opA;
		logic [31:0]       opB;
		logic              interrupt_priority_mask;
		logic              fault_mask_a;
		logic              halted;
		logic              undef;
		logic [3:0]        flags;
	} fpx_exec_state_type;

	fpx_exec_state_type st;
	fpx_exec_state_type next_st;

	logic        accept;
	logic        legal;
	logic        doIt;
	logic        sizeOk;
	logic        rangeOk;
	logic        handshake;
	logic        downward;
	logic        rspTake;
	logic        arithDone;
	logic [31:0] arithResult;
	logic [5:0]  cnt;
	logic [5:0]  words;
	logic [5:0]  wFirst;
	logic [31:0] bytes;
	logic [31:0] strAddr;

	fpx_arith u_arith (
		.core_clk (core_clk),
		.rst      (rst),
		.go       (st.arithGo),
		.sqrtOp   (st.arithSqrt),
		.opA      (st.opA),
		.opB      (st.opB),
		.done     (arithDone),
		.result   (arithResult)
	);

	// A single store moves exactly one register of the given width.
	assign cnt = (instr.op == OP_STR) ? ONE_REG : instr.count;
	assign words = instr.dbl ? {cnt[4:0], 1'b0} : cnt;
	assign wFirst = instr.dbl ? {instr.first, 1'b0} : {1'b0, instr.first};
	assign bytes = 32'(words) << WORD_SHIFT;
	assign strAddr = instr.immAdd ? instr.baseVal + 32'(instr.imm)
		: instr.baseVal - 32'(instr.imm);
	assign sizeOk = !instr.sizeGiven
		|| instr.sizeBits == (instr.dbl ? SIZE_DOUBLE : SIZE_SINGLE);
	assign rangeOk = (7'(wFirst) + 7'(words)) <= FP_WORDS;
	assign downward = instr.op == OP_PUSH || (instr.op == OP_STM && instr.decBefore);

	always_comb begin
		unique case (instr.op)
			OP_POP, OP_PUSH: legal = cnt != '0 && cnt <= LIST_MAX && sizeOk && rangeOk;
			OP_STM: legal = cnt != '0 && (!instr.dbl || cnt <= LIST_MAX) && sizeOk && rangeOk
				&& (!instr.decBefore || instr.writeback);
			OP_STR: legal = instr.imm[1:0] == 2'b00 && rangeOk;
			default: legal = 1'b1;
		endcase
	end

	assign instrReady = st.phase == PH_IDLE && !st.halted;
	assign accept = instrValid && instrReady;
	// Breakpoint and change-state ignore the condition; others skip when it fails.
	assign doIt = accept && legal
		&& (instr.condPass || instr.op == OP_BREAKPOINT_INSTR || instr.op == OP_CPS);
	// Loads wait for older accesses to drain, so every answer after that is theirs.
	assign memValid = st.phase == PH_XFER && st.wordsLeft != '0 && !st.fence
		&& (!st.isLoad || st.started || st.outstanding == '0);
	assign handshake = memValid && memReady;
	assign rspTake = st.phase != PH_IDLE && st.isLoad && st.started
		&& memRspValid && st.rspLeft != '0;

	always_comb begin
		next_st = st;
		next_st.wb.valid = 1'b0;
		next_st.undef = 1'b0;
		next_st.arithGo = 1'b0;
		next_st.outstanding = st.outstanding + 7'(handshake) - 7'(memRspValid);
		if (st.fence && next_st.outstanding == '0) next_st.fence = 1'b0;
		if (flagsLoad) next_st.flags = flagsIn;
		if (fpWrEn) next_st.fregs[fpWrIdx] = fpWrData;
		if (debugResume) next_st.halted = 1'b0;
		unique case (st.phase)
			PH_IDLE: if (accept && !legal) begin
				next_st.undef = 1'b1;
			end else if (doIt) begin
				unique case (instr.op)
					OP_POP, OP_PUSH, OP_STM, OP_STR: begin
						next_st.phase = PH_XFER;
						next_st.isLoad = instr.op == OP_POP;
						next_st.started = 1'b0;
						next_st.wordIdx = wFirst;
						next_st.rspIdx = wFirst;
						next_st.wordsLeft = words;
						next_st.rspLeft = (instr.op == OP_POP) ? words : '0;
						if (instr.op == OP_STR) next_st.addr = strAddr;
						else if (downward) next_st.addr = instr.baseVal - bytes;
						else next_st.addr = instr.baseVal;
						next_st.wbPend.valid = instr.op == OP_POP || instr.op == OP_PUSH
							|| (instr.op == OP_STM && instr.writeback);
						next_st.wbPend.idx = (instr.op == OP_STM) ? instr.baseIdx : SP_INDEX;
						next_st.wbPend.value = downward ? instr.baseVal - bytes
							: instr.baseVal + bytes;
					end
					OP_SQRT, OP_SUB: begin
						next_st.phase = PH_ARITH;
						next_st.arithGo = 1'b1;
						next_st.arithSqrt = instr.op == OP_SQRT;
						next_st.opA = st.fregs[(instr.op == OP_SQRT) ? instr.srcM : instr.srcN];
						next_st.opB = st.fregs[instr.srcM];
						next_st.dst = instr.dst;
					end
					// The immediate is left for the debugger to fetch from memory.
					OP_BREAKPOINT_INSTR: next_st.halted = 1'b1;
					OP_CPS: if (instr.privileged) begin
						if (instr.maskI) next_st.interrupt_priority_mask = instr.setMask;
						if (instr.maskF) next_st.fault_mask_a = instr.setMask;
					end
					OP_DMB: if (next_st.outstanding != '0) next_st.fence = 1'b1;
					default: ;
				endcase
			end
			PH_XFER: if (handshake) begin
				next_st.addr = st.addr + WORD_BYTES;
				next_st.wordIdx = st.wordIdx + ONE_REG;
				next_st.wordsLeft = st.wordsLeft - ONE_REG;
				next_st.started = 1'b1;
				if (st.wordsLeft == ONE_REG) begin
					if (st.isLoad) next_st.phase = PH_DRAIN;
					else begin
						next_st.phase = PH_IDLE;
						next_st.wb = st.wbPend;
					end
				end
			end
			PH_DRAIN: if (st.rspLeft == '0) begin
				next_st.phase = PH_IDLE;
				next_st.wb = st.wbPend;
			end
			PH_ARITH: if (arithDone) begin
				next_st.fregs[st.dst] = arithResult;
				next_st.phase = PH_IDLE;
			end
		endcase
		if (rspTake) begin
			next_st.fregs[st.rspIdx[4:0]] = memRdata;
			next_st.rspIdx = st.rspIdx + ONE_REG;
			next_st.rspLeft = st.rspLeft - ONE_REG;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) st <= '0;
		else st <= next_st;
	end

	assign memReq = '{write: !st.isLoad, addr: st.addr, wdata: st.fregs[st.wordIdx[4:0]]};
	assign coreWb = st.wb;
	assign fpRdData = st.fregs[fpRdIdx];
	assign flags = st.flags;
	assign intPriorityMask = st.interrupt_priority_mask;
	assign faultMaskA = st.fault_mask_a;
	assign debugHalted = st.halted;
	assign undefinedInstr = st.undef;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_push_go;
		doIt && instr.op == OP_PUSH;
	endsequence
	sequence s_pop_go;
		doIt && instr.op == OP_POP;
	endsequence
	sequence s_last_store;
		st.phase == PH_XFER && !st.isLoad && handshake && st.wordsLeft == ONE_REG;
	endsequence

	property p_pop_fill;
		rspTake |=> st.fregs[$past(st.rspIdx[4:0])] == $past(memRdata);
	endproperty
	a_pop_fill: assert property (p_pop_fill)
		else $error("pop answer not written to the expected register");

	property p_push_addr;
		s_push_go |=> memReq.addr == $past(instr.baseVal) - $past(bytes) && memReq.write;
	endproperty
	a_push_addr: assert property (p_push_addr)
		else $error("push does not start below the stack pointer");

	property p_pop_sp;
		s_pop_go |=> st.wbPend.idx == SP_INDEX
			&& st.wbPend.value == $past(instr.baseVal) + $past(bytes);
	endproperty
	a_pop_sp: assert property (p_pop_sp)
		else $error("pop stack pointer update wrong");

	property p_size_bad;
		accept && instr.op == OP_STM && instr.sizeGiven
			&& instr.sizeBits != (instr.dbl ? SIZE_DOUBLE : SIZE_SINGLE)
			|=> undefinedInstr && !memValid;
	endproperty
	a_size_bad: assert property (p_size_bad)
		else $error("size mismatch not refused");

	property p_ia_addr;
		doIt && instr.op == OP_STM && !instr.decBefore |=> memReq.addr == $past(instr.baseVal);
	endproperty
	a_ia_addr: assert property (p_ia_addr)
		else $error("increment-after store not at base");

	property p_db_needs_wb;
		accept && instr.op == OP_STM && instr.decBefore && !instr.writeback |=> undefinedInstr;
	endproperty
	a_db_needs_wb: assert property (p_db_needs_wb)
		else $error("decrement-before without writeback accepted");

	property p_wb_end;
		s_last_store ##0 st.wbPend.valid |=> coreWb.valid
			&& coreWb.value == $past(st.wbPend.value) ##1 !coreWb.valid;
	endproperty
	a_wb_end: assert property (p_wb_end)
		else $error("base writeback missing after store");

	property p_str_addr;
		doIt && instr.op == OP_STR |=> memReq.addr == $past(strAddr) && memValid;
	endproperty
	a_str_addr: assert property (p_str_addr)
		else $error("single store address wrong");

	property p_arith_wr;
		st.phase == PH_ARITH && arithDone |=> st.fregs[$past(st.dst)] == $past(arithResult);
	endproperty
	a_arith_wr: assert property (p_arith_wr)
		else $error("arithmetic result not written");

	property p_flags;
		!flagsLoad |=> $stable(flags);
	endproperty
	a_flags: assert property (p_flags)
		else $error("condition flags changed");

	property p_breakpoint_instr;
		accept && instr.op == OP_BREAKPOINT_INSTR |=> debugHalted && !instrReady;
	endproperty
	a_breakpoint_instr: assert property (p_breakpoint_instr)
		else $error("breakpoint did not halt");

	property p_cps_unpriv;
		accept && instr.op == OP_CPS && !instr.privileged
			|=> $stable(intPriorityMask) && $stable(faultMaskA);
	endproperty
	a_cps_unpriv: assert property (p_cps_unpriv)
		else $error("unprivileged change-state altered a mask");

	property p_cps_set;
		doIt && instr.op == OP_CPS && instr.privileged && instr.maskF
			|=> faultMaskA == $past(instr.setMask);
	endproperty
	a_cps_set: assert property (p_cps_set)
		else $error("fault mask not updated");

	property p_fence;
		st.fence |-> !memValid;
	endproperty
	a_fence: assert property (p_fence)
		else $error("access issued across the barrier");

	property p_nonmem;
		st.fence && st.phase == PH_IDLE && !st.halted |-> instrReady;
	endproperty
	a_nonmem: assert property (p_nonmem)
		else $error("barrier stalled a non-memory instruction");
endmodule

// ---- pkg/fpx_pkg.sv ----
// How it works
// - Register pop loads consecutive extension registers in order from successive stack words.
// - Register push stores consecutive extension registers onto the stack, one to sixteen.
// - A given size qualifier must equal the list register width, 32 or 64.
// - Square root writes the root of a single-precision source into the destination.
// - Increment-after multiple store uses ascending addresses from the base; it is default.
// - Decrement-before multiple store ends just below the base and needs writeback.
// - Requested writeback puts the updated address into the base register after transfer.
// - Single store address is base plus or minus a word-multiple immediate up to 1020.
// - Single store writes one single or doubleword register at the computed address.
// - Subtract writes first operand minus second operand into the destination.
// - None of these instructions change the core condition flags.
// - Breakpoint puts the processor in debug state for an attached debugger.
// - The 8-bit breakpoint immediate is ignored by the processor.
// - Breakpoint inside a conditional block executes regardless of the condition.
// - Mask-set form sets, mask-clear form clears; i picks priority mask, f fault mask.
// - The change-state instruction does nothing at the unprivileged level.
// - The barrier completes all earlier memory accesses before any later one starts.
// - The barrier does not hold back instructions that do not access memory.
package fpx_pkg;
	localparam logic [3:0]  SP_INDEX    = 4'hD;
	localparam logic [5:0]  LIST_MAX    = 6'h10;
	localparam logic [5:0]  ONE_REG     = 6'h01;
	localparam logic [6:0]  FP_WORDS    = 7'h20;
	localparam logic [6:0]  SIZE_SINGLE = 7'h20;
	localparam logic [6:0]  SIZE_DOUBLE = 7'h40;
	localparam int          WORD_SHIFT  = 2;
	localparam logic [31:0] WORD_BYTES  = 32'h4;
	localparam logic [31:0] QUIET_NAN   = 32'h7FC0_0000;
	localparam logic [7:0]  EXP_BIAS    = 8'h7F;
	localparam logic [7:0]  EXP_MAX     = 8'hFF;
	localparam logic [4:0]  SQRT_STEPS  = 5'h18;

	typedef enum logic [3:0] {
		OP_NONE, OP_POP, OP_PUSH, OP_STM, OP_STR, OP_SQRT, OP_SUB, OP_BREAKPOINT_INSTR, OP_CPS, OP_DMB
	} fpx_op_type;

	typedef struct packed {
		fpx_op_type  op;
		logic        condPass;
		logic        privileged;
		logic        sizeGiven;
		logic [6:0]  sizeBits;
		logic        dbl;
		logic        decBefore;
		logic        writeback;
		logic [4:0]  first;
		logic [5:0]  count;
		logic [4:0]  dst;
		logic [4:0]  srcN;
		logic [4:0]  srcM;
		logic [3:0]  baseIdx;
		logic [31:0] baseVal;
		logic        immAdd;
		logic [9:0]  imm;
		logic [7:0]  bkptImm;
		logic        maskI;
		logic        maskF;
		logic        setMask;
	} fpx_instr_type;

	typedef struct packed {
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fpx_mem_type;

	typedef struct packed {
		logic        valid;
		logic [3:0]  idx;
		logic [31:0] value;
	} fpx_wb_type;
endpackage
